// ==== logic/rdm_cmd_port.sv ====
/*
 Command, control and data-strobe port of a registered DDR module, as seen from the module.
 Link logic runs on the true clock of the differential pair; events cross to clk.
 Assumes the controller keeps clock enable high through every access and one data beat per link clock.
*/
// Functional notes
// - Module reset low clears every registered input output at once, without a clock.
// - Command is decoded from row, column, write strobes plus chip select as one code.
// - Inputs are sampled where the true clock rises as the complement clock falls.
// - Read data and strobes are driven relative to the differential clock crossings.
// - Clock enable high activates internal clock, inputs and drivers; low deactivates them.
// - Clock enable low enters precharge power-down or self refresh if idle, else active power-down.
// - Clock enable sampled for power-down and self-refresh entry; asynchronous for self-refresh exit, output disable.
// - Power-down keeps only clock pair, enable inputs; self refresh keeps true clock, enable.
// - Chip select registered low enables the decoder; high masks every command.
// - Two bank-select inputs choose the bank for activate, read, write, precharge.
// - Address carries row on activate, column on read/write; bit ten asks auto precharge.
// - Precharge with bit ten low closes the selected bank; high closes all banks.
// - Mode-register-set carries the operation code on the address inputs.
// - Bank-select inputs choose base or extended mode register on mode load.
// - Strobes driven edge-aligned with read data; controller strobes write data centred.
// - Read latency seen by controller is programmed CAS latency plus one clock.
`timescale 1ns/1ns
`default_nettype none

module rdm_cmd_port
	import rdm_pkg::*;
#(
	parameter int DEPTH_LOG2 = 6
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic module_reset_n,
	input wire logic diff_clock_true,
	input wire logic diff_clock_comp,
	input wire logic clock_enable_in,
	input wire logic rank_select_n,
	input wire logic row_strobe_n,
	input wire logic col_strobe_n,
	input wire logic write_en_n,
	input wire logic bank_select_lo,
	input wire logic bank_select_hi,
	input wire logic [RDM_ADDR_W-1:0] row_col_address,
	input wire logic [RDM_DL_W-1:0] data_lines_i,
	output logic [RDM_DL_W-1:0] data_lines_o,
	output logic [RDM_DL_W-1:0] data_lines_oe,
	input wire logic [RDM_CHK_W-1:0] check_bit_lines_i,
	output logic [RDM_CHK_W-1:0] check_bit_lines_o,
	output logic [RDM_CHK_W-1:0] check_bit_lines_oe,
	input wire logic [RDM_DS_W-1:0] data_strobes_i,
	output logic [RDM_DS_W-1:0] data_strobes_o,
	output logic [RDM_DS_W-1:0] data_strobes_oe,
	output logic reg_clock_enable,
	output logic [RDM_ADDR_W-1:0] base_mode,
	output logic [RDM_ADDR_W-1:0] ext_mode,
	output logic evt_valid,
	output rdm_evt_t evt
);
	localparam int COL_W = DEPTH_LOG2 - 2;
	localparam int WORD_W = RDM_DL_W + RDM_CHK_W;

	logic ce_r, ce_d_r, pair_ok_r, sel_n_r, row_n_r, col_n_r, wen_n_r;
	logic [1:0] bank_r;
	logic [RDM_ADDR_W-1:0] addr_r;
	logic [2:0] op;
	logic cmd_en, sref_req, sref_r, bufs_on;
	rdm_pwr_t pwr_r;
	logic [3:0] bank_open_r;
	logic [RDM_ADDR_W-1:0] mode_r, ext_r;
	logic [RDM_LAT_W-1:0] cas_lat;
	logic [RDM_BEAT_W-1:0] burst_len;
	logic start_rd, start_wr, rd_act, wr_act;
	logic [RDM_BEAT_W-1:0] rd_beat, wr_beat;
	logic [DEPTH_LOG2-1:0] rd_base_r, wr_base_r, rd_idx, wr_idx;
	logic [WORD_W-1:0] mem [2**DEPTH_LOG2];
	logic [RDM_DL_W-1:0] dl_o_r, dl_oe_r;
	logic [RDM_CHK_W-1:0] chk_o_r, chk_oe_r;
	logic [RDM_DS_W-1:0] ds_o_r, ds_oe_r;
	logic [2:0] pstat_d_r;
	logic evt_fire;
	rdm_evt_t evt_word;

	// Inputs are ignored while powered down or in self refresh
	assign bufs_on = (pwr_r == RDM_PS_ACT) && !sref_r;

	always_ff @(posedge diff_clock_true or negedge module_reset_n) begin
		if (!module_reset_n) begin
			ce_r <= 1'b0;
			ce_d_r <= 1'b0;
			pair_ok_r <= 1'b0;
			sel_n_r <= 1'b0;
			row_n_r <= 1'b0;
			col_n_r <= 1'b0;
			wen_n_r <= 1'b0;
			bank_r <= '0;
			addr_r <= '0;
		end else begin
			ce_r <= clock_enable_in;
			ce_d_r <= ce_r;
			pair_ok_r <= sref_r | !diff_clock_comp;
			if (bufs_on) begin
				sel_n_r <= rank_select_n;
				row_n_r <= row_strobe_n;
				col_n_r <= col_strobe_n;
				wen_n_r <= write_en_n;
				bank_r <= {bank_select_hi, bank_select_lo};
				addr_r <= row_col_address;
			end else begin
				sel_n_r <= 1'b1;
			end
		end
	end

	// Reset leaves the strobe registers low, so clock enable gates decode as well
	assign op = {row_n_r, col_n_r, wen_n_r};
	assign cmd_en = ce_r && pair_ok_r && !sel_n_r && !sref_r;
	assign sref_req = ce_d_r && !ce_r && pair_ok_r && !sel_n_r && op == RDM_OP_REF && bank_open_r == '0;

	always_ff @(posedge diff_clock_true or negedge module_reset_n) begin
		if (!module_reset_n) begin
			pwr_r <= RDM_PS_ACT;
		end else begin
			unique case (pwr_r)
				RDM_PS_ACT: begin
					if (ce_d_r && !ce_r && !sref_req && !sref_r) begin
						pwr_r <= (bank_open_r != '0) ? RDM_PS_APD : RDM_PS_PPD;
					end
				end
				RDM_PS_PPD, RDM_PS_APD: begin
					if (ce_r) begin
						pwr_r <= RDM_PS_ACT;
					end
				end
			endcase
		end
	end

	// Self-refresh exit must not wait for a clock that may have stopped
	always_ff @(posedge diff_clock_true or negedge module_reset_n or posedge clock_enable_in) begin
		if (!module_reset_n) begin
			sref_r <= 1'b0;
		end else if (clock_enable_in) begin
			sref_r <= 1'b0;
		end else if (sref_req) begin
			sref_r <= 1'b1;
		end
	end

	always_ff @(posedge diff_clock_true or negedge module_reset_n) begin
		if (!module_reset_n) begin
			bank_open_r <= '0;
		end else if (cmd_en) begin
			case (op)
				RDM_OP_ACT: bank_open_r[bank_r] <= 1'b1;
				RDM_OP_PRE: begin
					if (addr_r[RDM_AP_BIT]) begin
						bank_open_r <= '0;
					end else begin
						bank_open_r[bank_r] <= 1'b0;
					end
				end
				// Auto precharge closes the bank at issue; the burst itself still runs
				RDM_OP_RD, RDM_OP_WR: begin
					if (addr_r[RDM_AP_BIT]) begin
						bank_open_r[bank_r] <= 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge diff_clock_true or negedge module_reset_n) begin
		if (!module_reset_n) begin
			mode_r <= RDM_MODE_RST;
			ext_r <= RDM_EXT_RST;
		end else if (cmd_en && op == RDM_OP_LMR) begin
			if (bank_r == RDM_MR_BASE) begin
				mode_r <= addr_r;
			end else if (bank_r == RDM_MR_EXT) begin
				ext_r <= addr_r;
			end
		end
	end

	assign cas_lat = mode_r[RDM_CL_LSB +: RDM_LAT_W];

	always_comb begin
		case (mode_r[RDM_BL_LSB +: 3])
			3'h1: burst_len = 4'h2;
			3'h2: burst_len = 4'h4;
			3'h3: burst_len = 4'h8;
			default: burst_len = RDM_BL_DFLT;
		endcase
	end

	assign start_rd = cmd_en && op == RDM_OP_RD;
	assign start_wr = cmd_en && op == RDM_OP_WR;

	// Command register already costs one clock, so the sequencer waits CL more
	rdm_burst_seq u_rd_seq (
		.clk(diff_clock_true),
		.arst_n(module_reset_n),
		.start(start_rd),
		.lat(cas_lat),
		.len(burst_len),
		.active_r(rd_act),
		.beat_r(rd_beat)
	);

	rdm_burst_seq u_wr_seq (
		.clk(diff_clock_true),
		.arst_n(module_reset_n),
		.start(start_wr),
		.lat(RDM_WR_LAT),
		.len(burst_len),
		.active_r(wr_act),
		.beat_r(wr_beat)
	);

	always_ff @(posedge diff_clock_true or negedge module_reset_n) begin
		if (!module_reset_n) begin
			rd_base_r <= '0;
			wr_base_r <= '0;
		end else begin
			if (start_rd) begin
				rd_base_r <= {bank_r, addr_r[COL_W-1:0]};
			end
			if (start_wr) begin
				wr_base_r <= {bank_r, addr_r[COL_W-1:0]};
			end
		end
	end

	// Column wraps inside the bank, so a burst never spills into the next bank
	assign rd_idx = {rd_base_r[DEPTH_LOG2-1 -: 2], rd_base_r[COL_W-1:0] + COL_W'(rd_beat)};
	assign wr_idx = {wr_base_r[DEPTH_LOG2-1 -: 2], wr_base_r[COL_W-1:0] + COL_W'(wr_beat)};

	// Check bits are stored as opaque payload beside the data
	always_ff @(posedge diff_clock_true) begin
		if (wr_act) begin
			mem[wr_idx] <= {check_bit_lines_i, data_lines_i};
		end
	end

	// Falling clock enable kills the drivers at once, without waiting for an edge
	always_ff @(posedge diff_clock_true or negedge module_reset_n or negedge clock_enable_in) begin
		if (!module_reset_n) begin
			dl_o_r <= '0;
			dl_oe_r <= '0;
			chk_o_r <= '0;
			chk_oe_r <= '0;
			ds_o_r <= '0;
			ds_oe_r <= '0;
		end else if (!clock_enable_in) begin
			dl_o_r <= '0;
			dl_oe_r <= '0;
			chk_o_r <= '0;
			chk_oe_r <= '0;
			ds_o_r <= '0;
			ds_oe_r <= '0;
		end else begin
			dl_oe_r <= {RDM_DL_W{rd_act}};
			chk_oe_r <= {RDM_CHK_W{rd_act}};
			ds_oe_r <= {RDM_DS_W{rd_act}};
			ds_o_r <= {RDM_DS_W{rd_act && !rd_beat[0]}};
			{chk_o_r, dl_o_r} <= rd_act ? mem[rd_idx] : '0;
		end
	end

	assign evt_word = '{op: cmd_en ? op : RDM_OP_NOP, bank: bank_r, addr: addr_r, pwr: pwr_r, sref: sref_r};
	assign evt_fire = (cmd_en && op != RDM_OP_NOP) || {sref_r, pwr_r} != pstat_d_r;

	always_ff @(posedge diff_clock_true or negedge module_reset_n) begin
		if (!module_reset_n) begin
			pstat_d_r <= '0;
		end else begin
			pstat_d_r <= {sref_r, pwr_r};
		end
	end

	rdm_evt_sync u_evt_sync (
		.link_clk(diff_clock_true),
		.link_rst_n(module_reset_n),
		.fire(evt_fire),
		.data_in(evt_word),
		.clk(clk),
		.rst_n(rst_n),
		.valid_r(evt_valid),
		.data_r(evt)
	);

	assign data_lines_o = dl_o_r;
	assign data_lines_oe = dl_oe_r;
	assign check_bit_lines_o = chk_o_r;
	assign check_bit_lines_oe = chk_oe_r;
	assign data_strobes_o = ds_o_r;
	assign data_strobes_oe = ds_oe_r;
	assign reg_clock_enable = ce_r;
	assign base_mode = mode_r;
	assign ext_mode = ext_r;

	sequence s_rd_cl3;
		start_rd && cas_lat == 3'h3;
	endsequence
	sequence s_rd_quiet;
		(!start_rd && clock_enable_in)[*3];
	endsequence

	property p_rst_clear;
		@(posedge clk) disable iff (!rst_n)
		!module_reset_n |-> !reg_clock_enable && data_lines_oe == '0;
	endproperty
	a_rst_clear: assert property (p_rst_clear) else $error("registered outputs not low in reset");

	property p_rd_latency;
		@(posedge diff_clock_true) disable iff (!module_reset_n)
		s_rd_cl3 ##1 s_rd_quiet |=> data_lines_oe[0] && !$past(data_lines_oe[0], 2);
	endproperty
	a_rd_latency: assert property (p_rd_latency) else $error("read data not at CAS latency plus one");

	property p_strobe_pair;
		@(posedge diff_clock_true) disable iff (!module_reset_n)
		data_lines_oe[0] |-> data_strobes_oe[0] && check_bit_lines_oe[0];
	endproperty
	a_strobe_pair: assert property (p_strobe_pair) else $error("strobe or check bits not with data");

	property p_pd_entry;
		@(posedge diff_clock_true) disable iff (!module_reset_n)
		pwr_r == RDM_PS_ACT && ce_d_r && !ce_r && !sref_req && !sref_r
		|=> pwr_r == ($past(bank_open_r) != '0 ? RDM_PS_APD : RDM_PS_PPD);
	endproperty
	a_pd_entry: assert property (p_pd_entry) else $error("wrong power-down state entered");

	property p_sref_exit;
		@(posedge diff_clock_true) disable iff (!module_reset_n)
		$past(sref_r) && clock_enable_in |-> !sref_r;
	endproperty
	a_sref_exit: assert property (p_sref_exit) else $error("self refresh held with clock enable high");

	property p_ce_off;
		@(posedge diff_clock_true) disable iff (!module_reset_n)
		!clock_enable_in |-> data_strobes_oe == '0 && data_lines_oe == '0;
	endproperty
	a_ce_off: assert property (p_ce_off) else $error("drivers on while clock enable low");

	property p_mask;
		@(posedge diff_clock_true) disable iff (!module_reset_n)
		sel_n_r || pwr_r != RDM_PS_ACT |=> bank_open_r == $past(bank_open_r) && mode_r == $past(mode_r);
	endproperty
	a_mask: assert property (p_mask) else $error("masked command changed state");

	property p_act_open;
		@(posedge diff_clock_true) disable iff (!module_reset_n)
		cmd_en && op == RDM_OP_ACT |=> bank_open_r[$past(bank_r)];
	endproperty
	a_act_open: assert property (p_act_open) else $error("activate did not open the bank");

	property p_pre_all;
		@(posedge diff_clock_true) disable iff (!module_reset_n)
		cmd_en && op == RDM_OP_PRE && addr_r[RDM_AP_BIT] |=> bank_open_r == '0;
	endproperty
	a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open");

	property p_mode_load;
		@(posedge diff_clock_true) disable iff (!module_reset_n)
		cmd_en && op == RDM_OP_LMR && bank_r == RDM_MR_EXT |=> ext_r == $past(addr_r) && mode_r == $past(mode_r);
	endproperty
	a_mode_load: assert property (p_mode_load) else $error("wrong mode register loaded");
endmodule

`default_nettype wire

// ==== logic/rdm_pkg.sv ====
/*
 Shared constants and carrier types for the registered DDR module command port.
 Assumes a 13-bit row/column address, four internal banks and a 72-bit data word.
*/
`default_nettype none

package rdm_pkg;
	localparam int RDM_ADDR_W = 13;
	localparam int RDM_DL_W = 64;
	localparam int RDM_CHK_W = 8;
	localparam int RDM_DS_W = 18;
	localparam int RDM_LAT_W = 3;
	localparam int RDM_BEAT_W = 4;
	// Command codes: {row strobe, column strobe, write enable}, active low
	localparam logic [2:0] RDM_OP_LMR = 3'h0;
	localparam logic [2:0] RDM_OP_REF = 3'h1;
	localparam logic [2:0] RDM_OP_PRE = 3'h2;
	localparam logic [2:0] RDM_OP_ACT = 3'h3;
	localparam logic [2:0] RDM_OP_WR = 3'h4;
	localparam logic [2:0] RDM_OP_RD = 3'h5;
	localparam logic [2:0] RDM_OP_NOP = 3'h7;
	localparam int RDM_AP_BIT = 10;
	localparam int RDM_BL_LSB = 0;
	localparam int RDM_CL_LSB = 4;
	localparam logic [RDM_ADDR_W-1:0] RDM_MODE_RST = 13'h0032;
	localparam logic [RDM_ADDR_W-1:0] RDM_EXT_RST = 13'h0000;
	localparam logic [1:0] RDM_MR_BASE = 2'h0;
	localparam logic [1:0] RDM_MR_EXT = 2'h1;
	localparam logic [RDM_LAT_W-1:0] RDM_WR_LAT = 3'h1;
	localparam logic [RDM_BEAT_W-1:0] RDM_BL_DFLT = 4'h4;

	typedef enum logic [1:0] {RDM_PS_ACT, RDM_PS_PPD, RDM_PS_APD} rdm_pwr_t;

	typedef struct packed {
		logic [2:0] op;
		logic [1:0] bank;
		logic [RDM_ADDR_W-1:0] addr;
		rdm_pwr_t pwr;
		logic sref;
	} rdm_evt_t;
endpackage

`default_nettype wire

// ==== logic/rdm_burst_seq.sv ====
/*
 Latency and burst sequencer: after start, waits lat cycles, then stays active for len beats.
 Assumes start is a one-cycle pulse; a new start abandons the burst in progress.
*/
`timescale 1ns/1ns
`default_nettype none

module rdm_burst_seq
	import rdm_pkg::*;
#(
	parameter int LAT_W = RDM_LAT_W,
	parameter int CNT_W = RDM_BEAT_W
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic start,
	input wire logic [LAT_W-1:0] lat,
	input wire logic [CNT_W-1:0] len,
	output logic active_r,
	output logic [CNT_W-1:0] beat_r
);
	logic [LAT_W-1:0] wait_r;
	logic [CNT_W-1:0] len_r;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wait_r <= '0;
			len_r <= '0;
			active_r <= 1'b0;
			beat_r <= '0;
		end else if (start) begin
			active_r <= (lat <= LAT_W'(1));
			wait_r <= (lat > LAT_W'(1)) ? lat - LAT_W'(1) : '0;
			len_r <= len;
			beat_r <= '0;
		end else if (wait_r != '0) begin
			wait_r <= wait_r - LAT_W'(1);
			if (wait_r == LAT_W'(1)) begin
				active_r <= 1'b1;
			end
		end else if (active_r) begin
			if (beat_r == len_r - CNT_W'(1)) begin
				active_r <= 1'b0;
			end
			beat_r <= beat_r + CNT_W'(1);
		end
	end

	property p_burst_len;
		@(posedge clk) disable iff (!arst_n)
		$rose(active_r) && !start ##1 !start[*1] |-> beat_r == CNT_W'(1) || !active_r;
	endproperty
	a_burst_len: assert property (p_burst_len) else $error("burst beat count did not advance");
endmodule

`default_nettype wire

// ==== logic/rdm_evt_sync.sv ====
/*
 Carries command events from the link clock to the system clock by toggle and held word.
 Assumes events on the link side are at least one link period apart and clk is over 4x faster.
*/
`timescale 1ns/1ns
`default_nettype none

module rdm_evt_sync
	import rdm_pkg::*;
(
	input wire logic link_clk,
	input wire logic link_rst_n,
	input wire logic fire,
	input wire rdm_evt_t data_in,
	input wire logic clk,
	input wire logic rst_n,
	output logic valid_r,
	output rdm_evt_t data_r
);
	logic tog_r;
	rdm_evt_t hold_r;
	logic s1_r, s2_r, s3_r, seen_r;
	logic new_evt;

	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			tog_r <= 1'b0;
			hold_r <= '0;
		end else if (fire) begin
			tog_r <= ~tog_r;
			hold_r <= data_in;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= tog_r;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// The held word is stable long before the toggle is seen, so it is sampled directly
	assign new_evt = (s2_r == s3_r) && (s3_r != seen_r);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			seen_r <= 1'b0;
			valid_r <= 1'b0;
			data_r <= '0;
		end else begin
			valid_r <= new_evt;
			if (new_evt) begin
				seen_r <= s3_r;
				data_r <= hold_r;
			end
		end
	end

	property p_evt_pulse;
		@(posedge clk) disable iff (!rst_n)
		valid_r |=> !valid_r;
	endproperty
	a_evt_pulse: assert property (p_evt_pulse) else $error("event valid longer than one cycle");
endmodule

`default_nettype wire

// ==== dv/rdm_host_model.sv ====
/*
 Host controller model for the registered module port: commands, clock enable, write bursts.
 Assumes the bench makes the link clock and calls these tasks from one process at a time.
*/
`timescale 1ns/1ns
`default_nettype none

module rdm_host_model
	import rdm_pkg::*;
(
	input wire logic diff_clock_true,
	output logic clock_enable_in,
	output logic rank_select_n,
	output logic row_strobe_n,
	output logic col_strobe_n,
	output logic write_en_n,
	output logic bank_select_lo,
	output logic bank_select_hi,
	output logic [RDM_ADDR_W-1:0] row_col_address,
	output logic [RDM_DL_W-1:0] data_lines_i,
	output logic [RDM_CHK_W-1:0] check_bit_lines_i,
	output logic [RDM_DS_W-1:0] data_strobes_i
);
	initial begin
		clock_enable_in = 1'b0;
		rank_select_n = 1'b1;
		{row_strobe_n, col_strobe_n, write_en_n} = RDM_OP_NOP;
		{bank_select_hi, bank_select_lo} = 2'h0;
		row_col_address = '0;
		{check_bit_lines_i, data_lines_i} = '0;
		data_strobes_i = '0;
	end

	task automatic cmd(input logic [2:0] op, input logic [1:0] bank, input logic [RDM_ADDR_W-1:0] addr,
		input logic ce, input logic sel_n);
		@(posedge diff_clock_true);
		#2;
		clock_enable_in = ce;
		rank_select_n = sel_n;
		{row_strobe_n, col_strobe_n, write_en_n} = op;
		{bank_select_hi, bank_select_lo} = bank;
		row_col_address = addr;
		@(posedge diff_clock_true);
		#2;
		rank_select_n = 1'b1;
		{row_strobe_n, col_strobe_n, write_en_n} = RDM_OP_NOP;
		// Released lines show the inverse, so a stale value never looks valid
		{bank_select_hi, bank_select_lo} = ~bank;
		row_col_address = ~addr;
	endtask

	task automatic set_ce(input logic v, input bit sync);
		if (sync) begin
			@(posedge diff_clock_true);
			#2;
		end
		clock_enable_in = v;
	endtask

	// Strobe rises mid-word, centred in the data eye; clock enable stays high throughout
	task automatic wr_burst(input logic [1:0] bank, input logic [RDM_ADDR_W-1:0] col, input logic [71:0] w [4]);
		cmd(RDM_OP_WR, bank, col, 1'b1, 1'b0);
		for (int i = 0; i < 4; i++) begin
			@(posedge diff_clock_true);
			#2;
			{check_bit_lines_i, data_lines_i} = w[i];
			data_strobes_i = '0;
			#30;
			data_strobes_i = '1;
		end
		@(posedge diff_clock_true);
		#2;
		{check_bit_lines_i, data_lines_i} = ~w[3];
		data_strobes_i = '0;
	endtask
endmodule

`default_nettype wire

// ==== dv/tb_rdm_cmd_port.sv ====
/*
 Self-checking bench for the registered module command port, driven through the host model.
 Assumes the package constants and the hand-over timing: CL3 BL4 after reset, one beat per link clock.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_rdm_cmd_port
	import rdm_pkg::*;
;
	logic clk, rst_n, module_reset_n, diff_clock_true, comp_bad, comp_raw;
	// Complement falls 1 ns ahead of the true rise, so sampling it at that edge is not a race
	wire logic diff_clock_comp = comp_bad | comp_raw;
	logic clock_enable_in, rank_select_n, row_strobe_n, col_strobe_n, write_en_n;
	logic bank_select_lo, bank_select_hi, reg_clock_enable, evt_valid;
	logic [RDM_ADDR_W-1:0] row_col_address, base_mode, ext_mode;
	logic [RDM_DL_W-1:0] data_lines_i, data_lines_o, data_lines_oe;
	logic [RDM_CHK_W-1:0] check_bit_lines_i, check_bit_lines_o, check_bit_lines_oe;
	logic [RDM_DS_W-1:0] data_strobes_i, data_strobes_o, data_strobes_oe;
	rdm_evt_t evt;
	int n_fail, n_checks;
	logic [71:0] w [4];

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Link clock offset so its edges never coincide with clk edges
	initial begin
		diff_clock_true = 1'b0;
		#3;
		forever #32 diff_clock_true = ~diff_clock_true;
	end
	initial begin
		comp_raw = 1'b1;
		#2;
		forever #32 comp_raw = ~comp_raw;
	end

	rdm_host_model i_rdm_host_model (.diff_clock_true(diff_clock_true), .clock_enable_in(clock_enable_in),
		.rank_select_n(rank_select_n), .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
		.write_en_n(write_en_n), .bank_select_lo(bank_select_lo), .bank_select_hi(bank_select_hi),
		.row_col_address(row_col_address), .data_lines_i(data_lines_i), .check_bit_lines_i(check_bit_lines_i),
		.data_strobes_i(data_strobes_i));

	rdm_cmd_port #(.DEPTH_LOG2(6)) i_rdm_cmd_port (.clk(clk), .rst_n(rst_n), .module_reset_n(module_reset_n),
		.diff_clock_true(diff_clock_true), .diff_clock_comp(diff_clock_comp), .clock_enable_in(clock_enable_in),
		.rank_select_n(rank_select_n), .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
		.write_en_n(write_en_n), .bank_select_lo(bank_select_lo), .bank_select_hi(bank_select_hi),
		.row_col_address(row_col_address), .data_lines_i(data_lines_i), .data_lines_o(data_lines_o),
		.data_lines_oe(data_lines_oe), .check_bit_lines_i(check_bit_lines_i), .check_bit_lines_o(check_bit_lines_o),
		.check_bit_lines_oe(check_bit_lines_oe), .data_strobes_i(data_strobes_i), .data_strobes_o(data_strobes_o),
		.data_strobes_oe(data_strobes_oe), .reg_clock_enable(reg_clock_enable), .base_mode(base_mode),
		.ext_mode(ext_mode), .evt_valid(evt_valid), .evt(evt));

	task chk(input string what, input logic [71:0] exp, input logic [71:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", what, exp, got);
			n_fail++;
		end
	endtask

	task summarize;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Event fields compared as {op, bank, pwr, sref} under a mask
	task evt_chk(input logic [7:0] exp, input logic [7:0] mask, input bit want);
		bit seen;
		seen = 1'b0;
		for (int i = 0; i < 40 && !seen; i++) begin
			@(posedge clk);
			#1;
			seen = (evt_valid === 1'b1);
		end
		if (!want) begin
			chk("evt_none", 0, seen);
		end else if (!seen) begin
			$display("[ERR] evt_valid expected 1 seen 0");
			n_fail++;
			summarize();
		end else begin
			chk("evt", exp & mask, {evt.op, evt.bank, evt.pwr, evt.sref} & mask);
		end
	endtask

	task cmd_ev(input logic [2:0] op, input logic [1:0] bank, input logic [RDM_ADDR_W-1:0] addr);
		i_rdm_host_model.cmd(op, bank, addr, 1'b1, 1'b0);
		evt_chk({op, bank, RDM_PS_ACT, 1'b0}, 8'hFF, 1'b1);
		chk("evt_addr", addr, evt.addr);
	endtask

	task pwr(input logic ce, input rdm_pwr_t st);
		i_rdm_host_model.set_ce(ce, 1'b1);
		evt_chk({RDM_OP_NOP, 2'h0, st, 1'b0}, 8'hE7, 1'b1);
	endtask

	// Read burst; cut 1 drops clock enable, cut 2 pulls module reset, both as the first word appears
	task rd(input logic [1:0] bank, input logic [RDM_ADDR_W-1:0] col, input int cl, input int bl, input int w0,
		input int cut);
		logic on;
		logic ev;
		i_rdm_host_model.cmd(RDM_OP_RD, bank, col, 1'b1, 1'b0);
		for (int k = 1; k <= cl + bl + 1; k++) begin
			@(posedge diff_clock_true);
			#2;
			if (cut != 0 && k == cl + 1) begin
				if (cut == 1) begin
					i_rdm_host_model.set_ce(1'b0, 1'b0);
				end else begin
					module_reset_n = 1'b0;
				end
				#1;
				chk("oe_cut", 0, |{data_lines_oe, check_bit_lines_oe, data_strobes_oe});
				return;
			end
			#2;
			on = (k > cl) && (k <= cl + bl);
			ev = ((k - cl - 1) % 2) == 0;
			chk("rd_oe", {72{on}}, {check_bit_lines_oe, data_lines_oe});
			if (on) begin
				chk("rd_word", w[w0 + k - cl - 1], {check_bit_lines_o, data_lines_o});
				chk("rd_strobe", {{RDM_DS_W{1'b1}}, {RDM_DS_W{ev}}}, {data_strobes_oe, data_strobes_o});
			end
		end
	endtask

	task wr_rd;
		cmd_ev(RDM_OP_ACT, 2'h2, 13'h0123);
		i_rdm_host_model.wr_burst(2'h2, 13'h0004, w);
		rd(2'h2, 13'h0004, 3, 4, 0, 0);
	endtask

	task mode_load;
		i_rdm_host_model.cmd(RDM_OP_LMR, 2'h0, 13'h0021, 1'b1, 1'b1);
		evt_chk(8'h00, 8'h00, 1'b0);
		@(posedge diff_clock_true);
		#2;
		comp_bad = 1'b1;
		i_rdm_host_model.cmd(RDM_OP_LMR, 2'h0, 13'h0021, 1'b1, 1'b0);
		comp_bad = 1'b0;
		evt_chk(8'h00, 8'h00, 1'b0);
		chk("mode_kept", RDM_MODE_RST, base_mode);
		cmd_ev(RDM_OP_LMR, RDM_MR_BASE, 13'h0021);
		cmd_ev(RDM_OP_LMR, RDM_MR_EXT, 13'h0A5A);
		chk("modes", {13'h0021, 13'h0A5A}, {base_mode, ext_mode});
		rd(2'h2, 13'h0406, 2, 2, 2, 0);
		pwr(1'b0, RDM_PS_PPD);
		pwr(1'b1, RDM_PS_ACT);
	endtask

	task power;
		cmd_ev(RDM_OP_ACT, 2'h1, 13'h0055);
		cmd_ev(RDM_OP_ACT, 2'h3, 13'h0066);
		cmd_ev(RDM_OP_PRE, 2'h1, 13'h0000);
		pwr(1'b0, RDM_PS_APD);
		i_rdm_host_model.cmd(RDM_OP_ACT, 2'h0, 13'h0077, 1'b0, 1'b0);
		evt_chk(8'h00, 8'h00, 1'b0);
		pwr(1'b1, RDM_PS_ACT);
		cmd_ev(RDM_OP_PRE, 2'h0, 13'h0400);
		pwr(1'b0, RDM_PS_PPD);
		pwr(1'b1, RDM_PS_ACT);
		i_rdm_host_model.cmd(RDM_OP_REF, 2'h0, 13'h0000, 1'b0, 1'b0);
		evt_chk(8'h01, 8'h01, 1'b1);
		repeat (40) @(posedge clk);
		i_rdm_host_model.set_ce(1'b1, 1'b1);
		evt_chk(8'h00, 8'h01, 1'b1);
		repeat (2) @(posedge diff_clock_true);
	endtask

	task cuts;
		cmd_ev(RDM_OP_ACT, 2'h2, 13'h0123);
		rd(2'h2, 13'h0004, 2, 2, 0, 1);
		i_rdm_host_model.set_ce(1'b1, 1'b1);
		repeat (4) @(posedge diff_clock_true);
		rd(2'h2, 13'h0004, 2, 2, 0, 2);
		chk("rst_regs", {RDM_MODE_RST, RDM_EXT_RST, 1'b0}, {base_mode, ext_mode, reg_clock_enable});
	endtask

	initial begin
		rst_n = 1'b0;
		module_reset_n = 1'b0;
		comp_bad = 1'b0;
		n_fail = 0;
		n_checks = 0;
		w[0] = 72'hA5_0123456789ABCDEF;
		w[1] = 72'h3C_FEDCBA9876543210;
		w[2] = 72'h0F_00FF00FF00FF00FF;
		w[3] = 72'hC3_5A5A5A5AA5A5A5A5;
		repeat (10) @(posedge clk);
		chk("rst_regs", {RDM_MODE_RST, RDM_EXT_RST, 1'b0}, {base_mode, ext_mode, reg_clock_enable});
		chk("rst_out", 0, |{data_lines_o, data_lines_oe, check_bit_lines_o, check_bit_lines_oe,
			data_strobes_o, data_strobes_oe});
		#2;
		rst_n = 1'b1;
		module_reset_n = 1'b1;
		i_rdm_host_model.set_ce(1'b1, 1'b1);
		// Let a possible stray event after module reset pass before the first command
		repeat (40) @(posedge clk);
		wr_rd();
		mode_load();
		power();
		cuts();
		summarize();
	end
endmodule

`default_nettype wire
